// File: shared/flash_mode_pkg.sv
// package for the flash led mode control block
package flash_mode_pkg;
	// register byte offsets
	localparam logic [7:0] MODE_CTRL_OFS   = 8'h00;
	localparam logic [7:0] CURRENT_OFS     = 8'h04;
	localparam logic [7:0] PIN_CFG_OFS     = 8'h08;
	localparam logic [7:0] STATUS_OFS      = 8'h0c;
	// mode control field layout
	localparam int MODE_LSB   = 0;
	localparam int LEDEN_LSB  = 4;
	// current level field layout
	localparam int TORCH_LSB  = 0;
	localparam int FLASH_LSB  = 8;
	localparam int LEVEL_W    = 8;
	// pin config field layout
	localparam int PINFN_LSB  = 0;
	localparam int GPOUT_BIT  = 4;
	// status field layout
	localparam int ST_MODE_LSB  = 0;
	localparam int ST_LEVEL_LSB = 4;
	localparam int ST_FLASH_BIT = 12;
	localparam int ST_STORE_BIT = 13;
	localparam int ST_PIN_BIT   = 14;
	localparam int ST_PWR_BIT   = 15;
	localparam int ST_SINK_LSB  = 16;
	// forced voltage target in millivolts
	localparam logic [12:0] VM_TARGET_MV = 13'd4950;
	// current ceilings in milliamps, outer and middle sink
	localparam logic [11:0] DD_OUT_MA  = 12'd400;
	localparam logic [11:0] DD_MID_MA  = 12'd800;
	localparam logic [11:0] DDT_OUT_MA = 12'd445;
	localparam logic [11:0] DDT_MID_MA = 12'd890;
	localparam logic [11:0] ES_OUT_MA  = 12'd925;
	localparam logic [11:0] ES_MID_MA  = 12'd1850;
	localparam logic [11:0] EST_OUT_MA = 12'd1025;
	localparam logic [11:0] EST_MID_MA = 12'd2050;
	// programmed operating modes
	typedef enum logic [1:0] {
		MODE_SHUTDOWN,
		MODE_TORCH,
		MODE_FLASH,
		MODE_VOLTAGE
	} op_mode_t;
	// function of the shared pin
	typedef enum logic [1:0] {
		PIN_PWR_OD,
		PIN_PWR_PP,
		PIN_GPIO_OUT,
		PIN_GPIO_IN
	} pin_fn_t;
	// control pins, grouped
	typedef struct packed {
		logic strobe;
		logic burst_mask;
		logic volt_force;
		logic torch_force;
		logic storage_sel;
	} ctrl_pins_t;
	// what the analog side is told to do
	typedef struct packed {
		op_mode_t    mode;
		logic [7:0]  level;
		logic [2:0]  sink_en;
		logic        stage_on;
		logic        node_hiz;
		logic [12:0] volt_mv;
		logic [11:0] cap_out_ma;
		logic [11:0] cap_mid_ma;
	} drive_cmd_t;
	localparam logic [1:0] SYNC_W = 2'd2;
endpackage

// File: hw/flash_led_mode_control.sv
// mode control logic of a camera flash led driver
// Summary of operation
// - With the strobe low, led current follows the torch level.
// - With the strobe high in flash mode, led current follows the flash level.
// - The burst mask drops flash current to torch level at once.
// - Voltage force selects voltage mode with a 4.95 V target.
// - Torch force selects torch operation.
// - Torch force counts only in programmed shutdown or voltage mode.
// - In forced torch each sink follows its led channel enable bit.
// - Master reset low holds shutdown and resets the registers.
// - Master reset high lets the registers choose the mode.
// - Storage select low gives direct drive and its current caps.
// - Storage select high gives storage mode and its current caps.
// - The shared pin is gpio, open-drain or push-pull power ok.
// - As power ok, the pin asserts while the output is in regulation.
// - The inductor node is high impedance in shutdown.
`timescale 1ns/1ns
`default_nettype none
module flash_led_mode_control
	import flash_mode_pkg::*;
#(
	parameter bit THERM_VARIANT = 1'b0 // higher current caps
) (
	input  wire logic        clk_i,        // 10 MHz clock
	input  wire logic        srst_i,       // sync reset, high
	input  wire logic        haddr_sel_i,  // hsel
	input  wire logic [31:0] haddr_i,      // byte address
	input  wire logic [1:0]  htrans_i,     // transfer type
	input  wire logic        hwrite_i,     // write
	input  wire logic [2:0]  hsize_i,      // size
	input  wire logic [31:0] hwdata_i,     // write data
	input  wire logic        hready_i,     // bus ready
	output logic      [31:0] hrdata_o,     // read data
	output logic             hreadyout_o,  // slave ready
	output logic             hresp_o,      // always okay
	input  wire ctrl_pins_t  pins_i,       // control pins
	input  wire logic        hw_master_rst_n_i, // master reset, low
	input  wire logic        vout_in_reg_i,     // output in regulation
	input  wire logic        pin_in_i,     // shared pin level
	output logic             pin_out_o,    // shared pin drive
	output logic             pin_oe_n_o,   // shared pin enable, low
	output drive_cmd_t       drive_o       // analog command
);
	localparam logic [1:0] TRANS_NONSEQ = 2'b10;
	localparam logic [1:0] TRANS_SEQ    = 2'b11;
	localparam int         SINK_N       = 3; // led sinks
	// synchroniser stages
	ctrl_pins_t pins_s1_q;
	ctrl_pins_t pins_s2_q;
	logic       rstn_s1_q;
	logic       rstn_s2_q;
	logic       pwr_s1_q;
	logic       pwr_s2_q;
	logic       gin_s1_q;
	logic       gin_s2_q;
	// registers
	op_mode_t   mode_q;
	logic [2:0] led_en_q;
	logic [LEVEL_W-1:0] torch_lvl_q;
	logic [LEVEL_W-1:0] flash_lvl_q;
	pin_fn_t    pin_fn_q;
	logic       gp_out_q;
	// bus data phase
	logic       wr_pend_q;
	logic [7:0] wr_addr_q;
	logic       soft_rst;
	logic       addr_ok;
	logic [31:0] status;
	drive_cmd_t cmd_d;
	// decision stage between registers and analog command
	op_mode_t   mode_sel;
	logic       flash_now;
	logic       sink_allow;
	logic [2:0] sink_on;
	logic [LEVEL_W-1:0] level_sel;
	logic       stage_cut;
	logic [11:0] cap_out_sel;
	logic [11:0] cap_mid_sel;
	// shared pin next values and read mux
	logic       pin_out_d;
	logic       pin_oe_n_d;
	logic [31:0] rd_word;

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			pins_s1_q <= '0;
			pins_s2_q <= '0;
			rstn_s1_q <= 1'b0;
			rstn_s2_q <= 1'b0;
			pwr_s1_q  <= 1'b0;
			pwr_s2_q  <= 1'b0;
			gin_s1_q  <= 1'b0;
			gin_s2_q  <= 1'b0;
		end else begin
			pins_s1_q <= pins_i;
			pins_s2_q <= pins_s1_q;
			rstn_s1_q <= hw_master_rst_n_i;
			rstn_s2_q <= rstn_s1_q;
			pwr_s1_q  <= vout_in_reg_i;
			pwr_s2_q  <= pwr_s1_q;
			gin_s1_q  <= pin_in_i;
			gin_s2_q  <= gin_s1_q;
		end
	end

	// master reset clears the register file
	// the synchronised level is used so a short glitch cannot leave
	// half of the registers cleared and half written
	assign soft_rst = srst_i | ~rstn_s2_q;

	// address phase decode
	assign addr_ok = haddr_sel_i & hready_i &
	                 ((htrans_i == TRANS_NONSEQ) | (htrans_i == TRANS_SEQ));

	// write address capture for the data phase
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= '0;
		end else begin
			wr_pend_q <= addr_ok & hwrite_i;
			wr_addr_q <= haddr_i[7:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (soft_rst) begin
			mode_q      <= MODE_SHUTDOWN;
			led_en_q    <= '0;
			torch_lvl_q <= '0;
			flash_lvl_q <= '0;
			pin_fn_q    <= PIN_PWR_OD;
			gp_out_q    <= 1'b0;
		end else if (wr_pend_q) begin
			case (wr_addr_q)
				MODE_CTRL_OFS: begin
					mode_q   <= op_mode_t'(hwdata_i[MODE_LSB +: 2]);
					led_en_q <= hwdata_i[LEDEN_LSB +: 3];
				end
				CURRENT_OFS: begin
					torch_lvl_q <= hwdata_i[TORCH_LSB +: LEVEL_W];
					flash_lvl_q <= hwdata_i[FLASH_LSB +: LEVEL_W];
				end
				PIN_CFG_OFS: begin
					pin_fn_q <= pin_fn_t'(hwdata_i[PINFN_LSB +: 2]);
					gp_out_q <= hwdata_i[GPOUT_BIT];
				end
				default: begin
				end
			endcase
		end
	end

	// operating mode priority, master reset first
	always_comb begin
		mode_sel = mode_q;
		// voltage force overrides the programmed mode
		if (pins_s2_q.volt_force) begin
			mode_sel = MODE_VOLTAGE;
		end
		// torch force only from shutdown or voltage mode
		if (pins_s2_q.torch_force &&
		    (mode_q == MODE_SHUTDOWN || mode_q == MODE_VOLTAGE)) begin
			mode_sel = MODE_TORCH;
		end
		// master reset low wins over every request
		if (!rstn_s2_q) begin
			mode_sel = MODE_SHUTDOWN;
		end
	end

	// flash level only on an unmasked strobe
	// the mask needs no extra state, so it cuts in as soon as it is seen
	assign flash_now = (mode_sel == MODE_FLASH) && pins_s2_q.strobe &&
	                   !pins_s2_q.burst_mask;

	// torch level otherwise, nothing in shutdown or voltage mode
	always_comb begin
		level_sel  = '0;
		sink_allow = 1'b0;
		case (mode_sel)
			MODE_TORCH: begin
				level_sel  = torch_lvl_q;
				sink_allow = 1'b1;
			end
			MODE_FLASH: begin
				level_sel  = flash_now ? flash_lvl_q : torch_lvl_q;
				sink_allow = 1'b1;
			end
			default: begin
				level_sel  = '0;
				sink_allow = 1'b0;
			end
		endcase
	end

	// each sink follows its own channel enable bit
	for (genvar g = 0; g < SINK_N; g++) begin : g_sink
		assign sink_on[g] = sink_allow & led_en_q[g];
	end

	// current ceilings follow the storage select pin
	always_comb begin
		if (pins_s2_q.storage_sel) begin
			cap_out_sel = THERM_VARIANT ? EST_OUT_MA : ES_OUT_MA;
			cap_mid_sel = THERM_VARIANT ? EST_MID_MA : ES_MID_MA;
		end else begin
			cap_out_sel = THERM_VARIANT ? DDT_OUT_MA : DD_OUT_MA;
			cap_mid_sel = THERM_VARIANT ? DDT_MID_MA : DD_MID_MA;
		end
	end

	// stored charge carries the flash, so the stage stands aside
	assign stage_cut = pins_s2_q.storage_sel && (mode_sel == MODE_FLASH) &&
	                   pins_s2_q.strobe;

	// analog command assembled from the decisions above
	always_comb begin
		cmd_d            = '0;
		cmd_d.mode       = mode_sel;
		cmd_d.level      = level_sel;
		cmd_d.sink_en    = sink_on;
		cmd_d.node_hiz   = (mode_sel == MODE_SHUTDOWN);
		cmd_d.stage_on   = (mode_sel != MODE_SHUTDOWN) && !stage_cut;
		// fixed target only in voltage mode
		cmd_d.volt_mv    = (mode_sel == MODE_VOLTAGE) ? VM_TARGET_MV : '0;
		cmd_d.cap_out_ma = cap_out_sel;
		cmd_d.cap_mid_ma = cap_mid_sel;
	end

	// registered analog command
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			drive_o <= '0;
			drive_o.node_hiz <= 1'b1;
		end else begin
			drive_o <= cmd_d;
		end
	end

	always_comb begin
		pin_out_d  = 1'b0;
		pin_oe_n_d = 1'b1;
		case (pin_fn_q)
			PIN_PWR_OD: begin
				pin_out_d  = 1'b0;
				pin_oe_n_d = pwr_s2_q; // pull low when out of range
			end
			PIN_PWR_PP: begin
				pin_out_d  = pwr_s2_q;
				pin_oe_n_d = 1'b0;
			end
			PIN_GPIO_OUT: begin
				pin_out_d  = gp_out_q;
				pin_oe_n_d = 1'b0;
			end
			default: begin
				pin_out_d  = 1'b0;
				pin_oe_n_d = 1'b1;
			end
		endcase
	end

	// shared pin registered so a mode change never glitches it
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			pin_out_o  <= 1'b0;
			pin_oe_n_o <= 1'b1;
		end else begin
			pin_out_o  <= pin_out_d;
			pin_oe_n_o <= pin_oe_n_d;
		end
	end

	// status word for reads
	always_comb begin
		status = '0;
		status[ST_MODE_LSB +: 2]        = drive_o.mode;
		status[ST_LEVEL_LSB +: LEVEL_W] = drive_o.level;
		status[ST_FLASH_BIT]            = pins_s2_q.strobe;
		status[ST_STORE_BIT]            = pins_s2_q.storage_sel;
		status[ST_PIN_BIT]              = gin_s2_q;
		status[ST_PWR_BIT]              = pwr_s2_q;
		status[ST_SINK_LSB +: 3]        = drive_o.sink_en;
	end

	// readback word of the addressed register, unmapped reads give zero
	always_comb begin
		case (haddr_i[7:0])
			MODE_CTRL_OFS: rd_word = (32'(mode_q) << MODE_LSB) |
			                         (32'(led_en_q) << LEDEN_LSB);
			CURRENT_OFS:   rd_word = (32'(torch_lvl_q) << TORCH_LSB) |
			                         (32'(flash_lvl_q) << FLASH_LSB);
			PIN_CFG_OFS:   rd_word = (32'(pin_fn_q) << PINFN_LSB) |
			                         (32'(gp_out_q) << GPOUT_BIT);
			STATUS_OFS:    rd_word = status;
			default:       rd_word = 32'h0000_0000;
		endcase
	end

	// read data registered in the address phase, held until the next read
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			hrdata_o <= '0;
		end else if (addr_ok && !hwrite_i) begin
			hrdata_o <= rd_word;
		end
	end

	// zero wait state, always okay
	assign hreadyout_o = 1'b1;
	assign hresp_o     = 1'b0;
endmodule // flash_led_mode_control
`default_nettype wire

// File: testbench/flash_mode_sva.sv
// port checker for the flash mode control block
`timescale 1ns/1ns
`default_nettype none
module flash_mode_sva
	import flash_mode_pkg::*;
#(
	parameter bit THERM_VARIANT = 1'b0 // higher current caps
) (
	input wire logic       clk_i,             // clock
	input wire logic       srst_i,            // sync reset
	input wire ctrl_pins_t pins_i,            // control pins
	input wire logic       hw_master_rst_n_i, // master reset, low
	input wire logic       pin_out_o,         // shared pin drive
	input wire logic       pin_oe_n_o,        // shared pin enable, low
	input wire drive_cmd_t drive_o            // analog command
);
	// all checks on the one clock, quiet in reset
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (srst_i);

	a_shut_hiz: assert property (drive_o.node_hiz == (drive_o.mode == MODE_SHUTDOWN))
		else $error("inductor node drive wrong for mode");
	a_rst_shut: assert property (!hw_master_rst_n_i [*3] |=> drive_o.mode == MODE_SHUTDOWN)
		else $error("master reset did not force shutdown");
	a_volt_mv: assert property (drive_o.volt_mv == ((drive_o.mode == MODE_VOLTAGE) ? VM_TARGET_MV : 13'h0))
		else $error("voltage target wrong");
	a_sink_off: assert property (drive_o.mode inside {MODE_SHUTDOWN, MODE_VOLTAGE} |-> drive_o.sink_en == 3'h0)
		else $error("sinks enabled outside led modes");
	a_cap_direct: assert property ((!pins_i.storage_sel && hw_master_rst_n_i) [*5] ##0 drive_o.mode != MODE_SHUTDOWN
		|-> drive_o.cap_mid_ma == (THERM_VARIANT ? DDT_MID_MA : DD_MID_MA) && drive_o.cap_out_ma == (THERM_VARIANT ? DDT_OUT_MA : DD_OUT_MA))
		else $error("direct drive caps wrong");
	a_cap_store: assert property ((pins_i.storage_sel && hw_master_rst_n_i) [*5] ##0 drive_o.mode != MODE_SHUTDOWN
		|-> drive_o.cap_mid_ma == (THERM_VARIANT ? EST_MID_MA : ES_MID_MA) && drive_o.cap_out_ma == (THERM_VARIANT ? EST_OUT_MA : ES_OUT_MA))
		else $error("storage caps wrong");
	a_stage_store: assert property ((pins_i.storage_sel && pins_i.strobe) [*5] ##0 drive_o.mode == MODE_FLASH |-> !drive_o.stage_on)
		else $error("power stage on during stored flash");
	a_pin_default: assert property ($past(srst_i) |-> pin_oe_n_o && !pin_out_o)
		else $error("shared pin not released after reset");
endmodule // flash_mode_sva
bind flash_led_mode_control flash_mode_sva #(.THERM_VARIANT(THERM_VARIANT)) chk_u (.clk_i, .srst_i,
	.pins_i, .hw_master_rst_n_i, .pin_out_o, .pin_oe_n_o, .drive_o);
`default_nettype wire

// File: testbench/pin_partner.sv
// model of the camera and host driving the control pins
`timescale 1ns/1ns
`default_nettype none
module pin_partner
	import flash_mode_pkg::*;
(
	input  wire logic clk_i,    // clock
	output ctrl_pins_t pins_o,   // control pins
	output logic       rst_n_o,  // master reset, low
	output logic       in_reg_o  // output in regulation
);
	// every pin driven from time zero
	initial begin
		pins_o = '0;
		rst_n_o = 1'b0;
		in_reg_o = 1'b0;
	end
	// levels change just after an edge
	task automatic apply(input ctrl_pins_t p, input logic r, input logic v);
		@(posedge clk_i);
		pins_o <= p;
		rst_n_o <= r;
		in_reg_o <= v;
	endtask
endmodule // pin_partner
`default_nettype wire

// File: testbench/tb_top.sv
// self-checking bench for the flash mode control block
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin err_count++; \
	$display("Error t=%0t got %h exp %h", $time, g, e); end end
module tb_top;
	import flash_mode_pkg::*;
	logic        clk_i = 0, srst_i = 1, hsel = 0, hwrite = 0;
	logic [1:0]  htrans = 0;
	logic [31:0] haddr = 0, hwdata = 0, hrdata;
	logic        hreadyout, hresp, pin_out, pin_oe_n, rst_n, in_reg;
	ctrl_pins_t  pins;
	drive_cmd_t  drv;
	int          err_count = 0, total_checks = 0;
	always #50 clk_i = ~clk_i;
	pin_partner pm_u (.clk_i, .pins_o(pins), .rst_n_o(rst_n), .in_reg_o(in_reg));
	// shared pin has a pull-up when nobody drives it
	flash_led_mode_control dut_u (.clk_i, .srst_i, .haddr_sel_i(hsel),
		.haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
		.hwdata_i(hwdata), .hready_i(hreadyout), .hrdata_o(hrdata),
		.hreadyout_o(hreadyout), .hresp_o(hresp), .pins_i(pins),
		.hw_master_rst_n_i(rst_n), .vout_in_reg_i(in_reg),
		.pin_in_i(pin_oe_n ? 1'b1 : pin_out), .pin_out_o(pin_out),
		.pin_oe_n_o(pin_oe_n), .drive_o(drv));
	// one single word transfer, address then data phase
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
		output logic [31:0] r);
		@(posedge clk_i);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge clk_i); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk_i); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask
	task automatic end_of_test;
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	// cut a hang short
	initial begin
		repeat (5000) @(posedge clk_i);
		err_count++;
		end_of_test();
	end
	// register defaults, shared pin functions, then mode decisions
	initial begin
		logic [31:0] r;
		int pmw, em, tl, fl, led, lv;
		ctrl_pins_t p;
		logic rn;
		void'($urandom(32'hcb7a6c90));
		repeat (10) @(posedge clk_i);
		srst_i <= 1'b0;
		pm_u.apply('0, 1'b1, 1'b0);
		bus(PIN_CFG_OFS, 1'b0, 32'h0, r);
		`CHK(r, 32'h0)
		bus(8'h10, 1'b0, 32'h0, r);
		`CHK(r, 32'h0)
		for (int j = 0; j < 8; j++) begin
			led = $urandom_range(1, 0);
			bus(PIN_CFG_OFS, 1'b1, {27'h0, led[0], 2'h0, j[2:1]}, r);
			pm_u.apply('0, 1'b1, j[0]);
			repeat (5) @(posedge clk_i);
			`CHK(pin_oe_n, j[2:1] == 0 ? j[0] : j[2:1] == 3)
			if (j[2:1] == 1 || j[2:1] == 2) `CHK(pin_out, j[2:1] == 1 ? j[0] : led[0])
		end
		for (int i = 0; i < 40; i++) begin
			p = ctrl_pins_t'(5'($urandom));
			rn = ($urandom_range(3, 0) != 0);
			pm_u.apply(p, rn, 1'b1);
			repeat (5) @(posedge clk_i);
			pmw = i % 4;
			tl = $urandom_range(255, 0);
			fl = $urandom_range(255, 0);
			led = $urandom_range(7, 0);
			bus(CURRENT_OFS, 1'b1, {16'h0, fl[7:0], tl[7:0]}, r);
			bus(MODE_CTRL_OFS, 1'b1, {25'h0, led[2:0], 2'h0, pmw[1:0]}, r);
			bus(MODE_CTRL_OFS, 1'b0, 32'h0, r);
			if (!rn) begin
				pmw = 0;
				led = 0;
			end
			`CHK(r, 32'(pmw + led * 16))
			repeat (3) @(posedge clk_i);
			em = !rn ? 0 : (p.torch_force && pmw inside {0, 3}) ? 1 : p.volt_force ? 3 : pmw;
			`CHK(drv.mode, op_mode_t'(em))
			`CHK(drv.node_hiz, em == 0)
			`CHK(drv.sink_en, em inside {1, 2} ? led[2:0] : 3'h0)
			`CHK(drv.volt_mv, em == 3 ? VM_TARGET_MV : 13'h0)
			`CHK(drv.stage_on, em != 0 && !(p.storage_sel && em == 2 && p.strobe))
			lv = !(em inside {1, 2}) ? 0 : (em == 2 && p.strobe && !p.burst_mask) ? fl : tl;
			if (em inside {1, 2}) `CHK(drv.level, 8'(lv))
			if (em != 0) `CHK({drv.cap_out_ma, drv.cap_mid_ma}, p.storage_sel ? {ES_OUT_MA, ES_MID_MA} : {DD_OUT_MA, DD_MID_MA})
			bus(STATUS_OFS, 1'b0, 32'h0, r);
			`CHK(r, {13'h0, (em inside {1, 2}) ? led[2:0] : 3'h0, 2'b11, p.storage_sel, p.strobe, lv[7:0], 2'h0, em[1:0]})
			`CHK(hresp, 1'b0)
		end
		end_of_test();
	end
endmodule // tb_top
`default_nettype wire
